/* File: i2c_ctl.sv */
/*
 * control part of a multimaster two-wire interface: enable, exit from
 * communication, wait cancel, bus-released detection and start/stop
 * generation, with control, flag, status and monitor registers.
 * assumes byte shifting logic on the same clock reports status events
 * as one-cycle pulses and wait periods as levels.
 */
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - track bus released from start/stop
// - initial bus state from flag bit 1
// - control bits wait,en,exit,spie,wtim,ack,sta,sto
// - flag bits: rsv 0, busy 6, fail 7
// - control register resets to zero
// - disable clears status, busy and fail flags, monitors
// - enable set by write, cleared write/reset
// - exit releases lines, enters standby, self-clears
// - exit clears triggers and status flags
// - standby until stop+restart, address match or extension code
// - wait cancel releases wait, self-clears
// - ninth-clock transmit cancel releases data line
// - exit and wait cancel ignored when disabled
// - enable with clock high data low starts
// - control accepts bit and byte writes
// - start trigger generates start condition
// - stop trigger generates stop condition
// - busy with reservation off refuses start
module i2c_ctl
	import i2c_ctl_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// register port
	input wire logic [15:0] addr_i,
	input wire logic [7:0] wr_data_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rd_data_o,
	// events from the byte logic
	input wire logic ext_code_i,
	input wire logic addr_match_i,
	input wire logic transmit_i,
	input wire logic ack_det_i,
	input wire logic wait_i,
	input wire logic ninth_wait_i,
	// wait handshake and mode to the byte logic
	output logic wait_release_o,
	output logic standby_o,
	// two-wire pins, enable low while driving
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o
);
	line_if lines ();
	logic [7:0] ctrl; // control register
	logic rsv_disable; // flag bit 0
	logic init_start; // flag bit 1
	logic bus_busy_flag; // flag bit 6
	logic start_request_failed; // flag bit 7
	logic [7:0] status; // status register
	logic [1:0] mon; // line level monitors
	logic en_q; // enable one cycle late, for edge
	logic stop_seen; // stop observed during standby
	gen_state_t gen_state; // start/stop generator
	logic [8:0] hold_cnt; // generator hold counter
	logic wr_ctrl; // decoded writes
	logic wr_flag;
	logic enable;
	logic en_rise;
	logic exit_go; // exit action this cycle
	logic start_refuse; // start request refused this cycle
	logic start_go; // generator may begin a start
	logic stop_go;
	logic start_done;
	logic stop_done;
	logic cancel_go; // wait cancel takes effect

	line_sampler sampler (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.lines(lines)
	);

	// true when the given strobe hits the given address
	function automatic logic hit(input logic [15:0] a, input logic [15:0] t,
		input logic s);
		hit = s && (a == t);
	endfunction

	assign wr_ctrl = hit(addr_i, CTRL_ADDR, wr_i);
	assign wr_flag = hit(addr_i, FLAG_ADDR, wr_i);
	assign enable = ctrl[CTL_ENABLE];
	assign en_rise = enable && !en_q;
	// exit acts the cycle after it is stored, then the bit clears
	assign exit_go = enable && ctrl[CTL_EXIT];
	// refused when reservation is off and the bus is held
	assign start_refuse = wr_ctrl && enable && wr_data_i[CTL_START] &&
		rsv_disable && bus_busy_flag;
	// standby only lets a master restart after a stop
	assign start_go = enable && ctrl[CTL_START] && !exit_go &&
		gen_state == GEN_IDLE && (!standby_o || stop_seen);
	assign stop_go = enable && ctrl[CTL_STOP] && !exit_go &&
		!ctrl[CTL_START] && gen_state == GEN_IDLE;
	assign start_done = gen_state == GEN_START &&
		hold_cnt == 9'(COND_HOLD_CYC - 1);
	assign stop_done = gen_state == GEN_STOP_REL &&
		(lines.stop_det || hold_cnt == 9'(COND_HOLD_CYC - 1));
	assign cancel_go = enable && ctrl[CTL_WAIT_CANCEL] && wait_i;

	// control register: byte writes, self clears and hardware clears
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			ctrl <= CTRL_RESET;
		end else if (wr_ctrl) begin
			// a single-bit write arrives as a full byte
			ctrl <= wr_data_i;
			// action bits have no effect while disabled
			if (!enable) begin
				ctrl[CTL_EXIT] <= 1'b0;
				ctrl[CTL_WAIT_CANCEL] <= 1'b0;
			end
			if (start_refuse)
				ctrl[CTL_START] <= 1'b0;
		end else begin
			if (exit_go) begin
				// abandon any pending trigger
				ctrl[CTL_EXIT] <= 1'b0;
				ctrl[CTL_START] <= 1'b0;
				ctrl[CTL_STOP] <= 1'b0;
			end
			if (start_done)
				ctrl[CTL_START] <= 1'b0;
			if (stop_done)
				ctrl[CTL_STOP] <= 1'b0;
			if (cancel_go)
				ctrl[CTL_WAIT_CANCEL] <= 1'b0;
		end
	end

	// flag register: software bits and bus-released tracking
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			rsv_disable <= FLAG_RESET[FLG_RSV_DISABLE];
			init_start <= FLAG_RESET[FLG_INIT_START];
			bus_busy_flag <= FLAG_RESET[FLG_BUSY];
			start_request_failed <= FLAG_RESET[FLG_START_FAIL];
		end else begin
			if (wr_flag) begin
				rsv_disable <= wr_data_i[FLG_RSV_DISABLE];
				init_start <= wr_data_i[FLG_INIT_START];
			end
			if (!enable) begin
				// disabled: busy and fail flags held clear
				bus_busy_flag <= 1'b0;
				start_request_failed <= 1'b0;
			end else if (en_rise) begin
				// bus not yet observed: take the preset state
				// a start seen at enable counts at once
				bus_busy_flag <= !init_start ||
					(lines.scl_lvl && !lines.sda_lvl);
			end else if (lines.start_det) begin
				bus_busy_flag <= 1'b1;
			end else if (lines.stop_det) begin
				bus_busy_flag <= 1'b0;
			end
			if (enable && start_refuse)
				start_request_failed <= 1'b1;
			else if (enable && start_go)
				start_request_failed <= 1'b0;
		end
	end

	// status register: events set, exit clears, set wins
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			status <= STATUS_RESET;
		end else if (!enable) begin
			status <= STATUS_RESET;
		end else begin
			if (exit_go)
				status <= STATUS_RESET;
			if (cancel_go && ninth_wait_i && status[ST_TRANSMIT])
				status[ST_TRANSMIT] <= 1'b0;
			if (start_done)
				status[ST_MASTER] <= 1'b1;
			if (ext_code_i)
				status[ST_EXT_CODE] <= 1'b1;
			if (addr_match_i)
				status[ST_ADDR_MATCH] <= 1'b1;
			if (transmit_i)
				status[ST_TRANSMIT] <= 1'b1;
			if (ack_det_i)
				status[ST_ACK_DET] <= 1'b1;
			if (lines.start_det || (en_rise && lines.scl_lvl &&
				!lines.sda_lvl)) begin
				status[ST_START_DET] <= 1'b1;
				status[ST_STOP_DET] <= 1'b0;
			end
			if (lines.stop_det) begin
				status[ST_STOP_DET] <= 1'b1;
				status[ST_MASTER] <= 1'b0;
			end
		end
	end

	// line monitors read zero while disabled
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i)
			mon <= 2'h0;
		else if (!enable)
			mon <= 2'h0;
		else
			mon <= {lines.scl_lvl, lines.sda_lvl};
	end

	// enable edge tracking
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i)
			en_q <= 1'b0;
		else
			en_q <= enable;
	end

	// standby: entered on exit, left on restart or being addressed
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			standby_o <= 1'b0;
			stop_seen <= 1'b0;
		end else if (!enable) begin
			standby_o <= 1'b0;
			stop_seen <= 1'b0;
		end else if (exit_go) begin
			standby_o <= 1'b1;
			stop_seen <= 1'b0;
		end else if (standby_o) begin
			if (lines.stop_det)
				stop_seen <= 1'b1;
			// leave on master restart, address match or extension code
			if ((stop_seen && start_go) || ((addr_match_i ||
				ext_code_i) && status[ST_START_DET])) begin
				standby_o <= 1'b0;
				stop_seen <= 1'b0;
			end
		end
	end

	// start/stop generator; internal operation stops when disabled
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			gen_state <= GEN_IDLE;
			hold_cnt <= 9'h000;
		end else if (!enable || exit_go) begin
			gen_state <= GEN_IDLE;
			hold_cnt <= 9'h000;
		end else begin
			case (gen_state)
				GEN_IDLE: begin
					hold_cnt <= 9'h000;
					if (start_go)
						gen_state <= GEN_START;
					else if (stop_go)
						gen_state <= GEN_STOP_LOW;
				end
				GEN_START: begin
					hold_cnt <= hold_cnt + 9'h001;
					if (start_done)
						gen_state <= GEN_IDLE;
				end
				GEN_STOP_LOW: begin
					hold_cnt <= hold_cnt + 9'h001;
					if (hold_cnt == 9'(COND_HOLD_CYC - 1)) begin
						gen_state <= GEN_STOP_REL;
						hold_cnt <= 9'h000;
					end
				end
				default: begin
					hold_cnt <= hold_cnt + 9'h001;
					if (stop_done)
						gen_state <= GEN_IDLE;
				end
			endcase
		end
	end

	// data line: pulled low for start and stop set-up
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			sda_oe_o <= 1'b1;
		end else if (!enable || exit_go) begin
			sda_oe_o <= 1'b1;
		end else if (cancel_go && ninth_wait_i && status[ST_TRANSMIT]) begin
			sda_oe_o <= 1'b1;
		end else if (start_go || stop_go) begin
			sda_oe_o <= 1'b0;
		end else if (gen_state == GEN_STOP_LOW &&
			hold_cnt == 9'(COND_HOLD_CYC - 1)) begin
			sda_oe_o <= 1'b1; // rising data with clock high
		end
	end

	// clock line held low during a wait until cancelled
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i)
			scl_oe_o <= 1'b1;
		else
			scl_oe_o <= !(enable && !exit_go && !standby_o && wait_i &&
				!ctrl[CTL_WAIT_CANCEL] && !wait_release_o);
	end

	// wait release pulse and constant low drive levels
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			wait_release_o <= 1'b0;
			scl_o <= 1'b0;
			sda_o <= 1'b0;
		end else begin
			wait_release_o <= cancel_go;
			scl_o <= 1'b0;
			sda_o <= 1'b0;
		end
	end

	// read data, valid the cycle after the strobe; unmapped reads zero
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i)
			rd_data_o <= 8'h00;
		else if (hit(addr_i, CTRL_ADDR, rd_i))
			rd_data_o <= ctrl;
		else if (hit(addr_i, FLAG_ADDR, rd_i))
			rd_data_o <= {start_request_failed, bus_busy_flag, 4'h0,
				init_start, rsv_disable};
		else if (hit(addr_i, STATUS_ADDR, rd_i))
			rd_data_o <= status;
		else if (hit(addr_i, MON_ADDR, rd_i))
			rd_data_o <= {6'h00, mon};
		else
			rd_data_o <= 8'h00;
	end

	property p_en_by_write;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		$rose(enable) |-> $past(wr_ctrl) && $past(wr_data_i[CTL_ENABLE]);
	endproperty
	a_en_by_write: assert property (p_en_by_write)
		else $error("enable rose without a write");

	property p_reset_clear;
		@(posedge ref_clk_i) !rst_b_i |=> ctrl == 8'h00;
	endproperty
	a_reset_clear: assert property (p_reset_clear)
		else $error("control not zero after reset");

	property p_disable_clear;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		!enable ##1 !enable |-> status == 8'h00 && !bus_busy_flag &&
			!start_request_failed && mon == 2'h0;
	endproperty
	a_disable_clear: assert property (p_disable_clear)
		else $error("state not cleared while disabled");

	property p_exit_action;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		exit_go && !wr_ctrl |=> standby_o && sda_oe_o && !ctrl[CTL_EXIT] &&
			!ctrl[CTL_START] && !ctrl[CTL_STOP];
	endproperty
	a_exit_action: assert property (p_exit_action)
		else $error("exit did not release and self clear");

	property p_ignore_disabled;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		wr_ctrl && !enable |=> !ctrl[CTL_EXIT] && !ctrl[CTL_WAIT_CANCEL];
	endproperty
	a_ignore_disabled: assert property (p_ignore_disabled)
		else $error("action bit stored while disabled");

	property p_refuse;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		start_refuse |=> start_request_failed && !ctrl[CTL_START];
	endproperty
	a_refuse: assert property (p_refuse)
		else $error("busy start request not refused");

	property p_stop_frees;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		enable && !en_rise && lines.stop_det && !lines.start_det
			&& !wr_ctrl |=> !bus_busy_flag;
	endproperty
	a_stop_frees: assert property (p_stop_frees)
		else $error("bus still busy after stop");

	property p_wait_cancel;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		cancel_go && !wr_ctrl |=> wait_release_o && !ctrl[CTL_WAIT_CANCEL];
	endproperty
	a_wait_cancel: assert property (p_wait_cancel)
		else $error("wait cancel not executed");

	property p_start_gen;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		start_go |=> !sda_oe_o && gen_state == GEN_START;
	endproperty
	a_start_gen: assert property (p_start_gen)
		else $error("start not generated");
endmodule
`default_nettype wire

/* File: i2c_ctl_pkg.sv */
/*
 * constants for the two-wire control block: register offsets, bit
 * positions, reset values and timing counts.
 * assumes a 100 MHz system clock and a 16-bit register address port.
 */
`default_nettype none
package i2c_ctl_pkg;
	// register byte addresses
	localparam logic [15:0] CTRL_ADDR = 16'hFFA6;
	localparam logic [15:0] FLAG_ADDR = 16'hFFA7;
	localparam logic [15:0] STATUS_ADDR = 16'hFFA8;
	localparam logic [15:0] MON_ADDR = 16'hFFA9;
	// control register fields
	localparam int CTL_WAIT_CANCEL = 7;
	localparam int CTL_ENABLE = 6;
	localparam int CTL_EXIT = 5;
	localparam int CTL_STOP_IRQ_EN = 4;
	localparam int CTL_WAIT_TIMING = 3;
	localparam int CTL_ACK_EN = 2;
	localparam int CTL_START = 1;
	localparam int CTL_STOP = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// flag register fields
	localparam int FLG_RSV_DISABLE = 0;
	localparam int FLG_INIT_START = 1;
	localparam int FLG_BUSY = 6;
	localparam int FLG_START_FAIL = 7;
	localparam logic [7:0] FLAG_RESET = 8'h00;
	// status register fields
	localparam int ST_MASTER = 7;
	localparam int ST_EXT_CODE = 5;
	localparam int ST_ADDR_MATCH = 4;
	localparam int ST_TRANSMIT = 3;
	localparam int ST_ACK_DET = 2;
	localparam int ST_START_DET = 1;
	localparam int ST_STOP_DET = 0;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	// monitor register fields
	localparam int MON_CLOCK = 1;
	localparam int MON_DATA = 0;
	// timing: hold of a generated start or stop level
	localparam int CLK_PERIOD_PS = 10000;
	localparam int COND_HOLD_NS = 4000;
	localparam int COND_HOLD_CYC =
		(COND_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// generator states
	typedef enum logic [1:0] {
		GEN_IDLE,
		GEN_START,
		GEN_STOP_LOW,
		GEN_STOP_REL
	} gen_state_t;
endpackage
`default_nettype wire

/* File: line_if.sv */
/*
 * carrier between the line sampler and the control block: filtered
 * line levels and one-cycle start and stop condition pulses.
 * assumes both ends run on the same system clock.
 */
`timescale 1ns/10ps
`default_nettype none
interface line_if;
	logic scl_lvl; // filtered clock line level
	logic sda_lvl; // filtered data line level
	logic start_det; // one-cycle start condition pulse
	logic stop_det; // one-cycle stop condition pulse
	modport src (output scl_lvl, sda_lvl, start_det, stop_det);
	modport snk (input scl_lvl, sda_lvl, start_det, stop_det);
endinterface
`default_nettype wire

/* File: line_sampler.sv */
/*
 * three-stage synchroniser for the clock and data lines with agreement
 * filter and start/stop condition detection.
 * assumes the line pins are asynchronous to ref_clk_i.
 */
`timescale 1ns/10ps
`default_nettype none
module line_sampler (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// raw pins
	input wire logic scl_i,
	input wire logic sda_i,
	// filtered view
	line_if.src lines
);
	logic [2:0] scl_sync; // synchroniser chain, bit 0 first
	logic [2:0] sda_sync;
	logic scl_f; // accepted levels
	logic sda_f;

	// chain: the first stage feeds only the second
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			scl_sync <= 3'h7;
			sda_sync <= 3'h7;
		end else begin
			scl_sync <= {scl_sync[1:0], scl_i};
			sda_sync <= {sda_sync[1:0], sda_i};
		end
	end

	// a level counts once stages two and three agree
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			scl_f <= 1'b1;
			sda_f <= 1'b1;
			lines.start_det <= 1'b0;
			lines.stop_det <= 1'b0;
		end else begin
			if (scl_sync[1] == scl_sync[2])
				scl_f <= scl_sync[2];
			if (sda_sync[1] == sda_sync[2])
				sda_f <= sda_sync[2];
			// data edge while clock stays high
			lines.start_det <= scl_f && (scl_sync[1] == scl_sync[2]) &&
				scl_sync[2] && sda_f && (sda_sync[1] == sda_sync[2]) &&
				!sda_sync[2];
			lines.stop_det <= scl_f && (scl_sync[1] == scl_sync[2]) &&
				scl_sync[2] && !sda_f && (sda_sync[1] == sda_sync[2]) &&
				sda_sync[2];
		end
	end

	assign lines.scl_lvl = scl_f;
	assign lines.sda_lvl = sda_f;
endmodule
`default_nettype wire

/* File: bus_partner.sv */
/* far side of the two-wire bus: another master or slave that pulls
 * the lines low or lets them go.
 * assumes pull-ups, so a released line reads high, and a 125 ns link
 * clock that only runs inside a frame. */
`timescale 1ns/10ps
`default_nettype none
module bus_partner (
	// open-drain releases, high = line let go
	output var logic scl_rel_o,
	output var logic sda_rel_o
);
	// half period of the link clock in ns
	localparam real HALF_NS = 62.5;
	// both lines released until a task pulls them
	initial begin
		scl_rel_o = 1'b1;
		sda_rel_o = 1'b1;
	end
	// data moves alone with clock high: low is a start, high a stop
	task automatic set_data(input logic v);
		sda_rel_o = v;
	endtask
	// start, then clock low so the frame is open
	task automatic start_frame;
		sda_rel_o = 1'b0;
		#HALF_NS scl_rel_o = 1'b0;
	endtask
	// link clock pulses with data held; idle clock stays still
	task automatic clocks(input int n);
		repeat (n) begin
			#HALF_NS scl_rel_o = 1'b1;
			#HALF_NS scl_rel_o = 1'b0;
		end
	endtask
	// data low, clock up, then data up: stop closes the frame
	task automatic stop_frame;
		sda_rel_o = 1'b0;
		#HALF_NS scl_rel_o = 1'b1;
		#HALF_NS sda_rel_o = 1'b1;
	endtask
endmodule
`default_nettype wire

/* File: i2c_control_enable_release_tb_top.sv */
/* bench for the two-wire control block: register traffic, a bus
 * partner and queued read checks.
 * assumes the block samples its raw pins through its own synchroniser. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
$display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module i2c_control_enable_release_tb_top
	import i2c_ctl_pkg::*;
;
	logic ref_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [15:0] addr_i = 16'h0000;
	logic [7:0] wr_data_i = 8'h00;
	logic wr_i = 1'b0, rd_i = 1'b0;
	logic ext_code_i = 1'b0, addr_match_i = 1'b0, transmit_i = 1'b0;
	logic ack_det_i = 1'b0, wait_i = 1'b0, ninth_wait_i = 1'b0;
	logic [7:0] rd_data_o;
	logic wait_release_o, standby_o, scl_o, scl_oe_o, sda_o, sda_oe_o;
	logic m_scl, m_sda; // partner releases
	logic scl_line, sda_line; // wired-and bus with pull-ups
	int error_cnt = 0, tests_run = 0, n;
	logic [7:0] exp_q[$], msk_q[$]; // expected reads, oldest first
	logic [7:0] mon_got, mon_exp, r;
	logic rd_seen = 1'b0; // read strobe was taken last edge
	// a pin is low if anyone drives it, else the pull-up wins
	assign scl_line = (scl_oe_o ? 1'b1 : scl_o) & m_scl;
	assign sda_line = (sda_oe_o ? 1'b1 : sda_o) & m_sda;
	initial forever #5 ref_clk_i = ~ref_clk_i;
	i2c_ctl u_i2c_ctl (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
		.addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
		.rd_data_o(rd_data_o), .ext_code_i(ext_code_i),
		.addr_match_i(addr_match_i), .transmit_i(transmit_i),
		.ack_det_i(ack_det_i), .wait_i(wait_i), .ninth_wait_i(ninth_wait_i),
		.wait_release_o(wait_release_o), .standby_o(standby_o),
		.scl_i(scl_line), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
		.sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe_o));
	bus_partner u_bus_partner (.scl_rel_o(m_scl), .sda_rel_o(m_sda));
	// read data stands only the cycle after the strobe, so look there
	always @(posedge ref_clk_i) begin
		rd_seen <= rd_i;
		if (rd_seen && exp_q.size() > 0) begin
			mon_got = rd_data_o & msk_q.pop_front();
			mon_exp = exp_q.pop_front();
			`CHK(mon_got, mon_exp)
		end
	end
	task automatic cyc(input int c);
		repeat (c) @(posedge ref_clk_i);
	endtask
	// one-cycle write strobe; an idle edge follows so strobes never clash
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		addr_i <= a;
		wr_data_i <= d;
		wr_i <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask
	// one-cycle read strobe; the monitor compares the masked byte
	task automatic rd(input logic [15:0] a, input logic [7:0] e, m);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
	endtask
	task automatic done(input string s);
		$display("test %s over", s);
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// hang guard: a run that never ends counts as a mismatch
	initial begin
		#1000000;
		error_cnt++;
		conclude();
	end
	initial begin
		void'($urandom(41157));
		r = 8'($urandom()) & 8'h1C; // random mode bits
		cyc(4);
		rst_b_i <= 1'b1;
		rd(CTRL_ADDR, 8'h00, 8'hFF);
		rd(FLAG_ADDR, FLAG_RESET, 8'hFF);
		rd(16'h0000, 8'h00, 8'hFF);
		`CHK(standby_o, 1'b0)
		wr(CTRL_ADDR, 8'hA0);
		rd(CTRL_ADDR, 8'h00, 8'hFF);
		done("reset");
		// mode bits go in with the enable write, lines both high
		wr(FLAG_ADDR, 8'h02);
		wr(CTRL_ADDR, 8'h40 | r);
		rd(CTRL_ADDR, 8'h40 | r, 8'hFF);
		rd(FLAG_ADDR, 8'h02, 8'hFF);
		rd(MON_ADDR, 8'h03, 8'hFF);
		wr(CTRL_ADDR, 8'h60 | r);
		cyc(3);
		`CHK(standby_o, 1'b1)
		`CHK({scl_oe_o, sda_oe_o}, 2'b11)
		rd(CTRL_ADDR, 8'h40 | r, 8'hFF);
		wr(CTRL_ADDR, 8'h00);
		rd(CTRL_ADDR, 8'h00, 8'hFF);
		wr(FLAG_ADDR, 8'h00);
		wr(CTRL_ADDR, 8'h40);
		rd(FLAG_ADDR, 8'h40, 8'hFF);
		wr(CTRL_ADDR, 8'h00);
		rd(FLAG_ADDR, 8'h00, 8'hFF);
		rd(MON_ADDR, 8'h00, 8'hFF);
		done("enable and exit");
		// enabling onto a held-low data line counts as a start
		u_bus_partner.set_data(1'b0);
		cyc(10);
		wr(FLAG_ADDR, 8'h02);
		wr(CTRL_ADDR, 8'h40);
		rd(FLAG_ADDR, 8'h42, 8'hFF);
		wr(CTRL_ADDR, 8'h60);
		u_bus_partner.set_data(1'b1);
		cyc(10);
		rd(FLAG_ADDR, 8'h02, 8'hFF);
		done("start on enable");
		// own start then own stop
		wr(CTRL_ADDR, 8'h42);
		cyc(3);
		`CHK(sda_oe_o, 1'b0)
		cyc(10);
		rd(FLAG_ADDR, 8'h42, 8'hFF);
		cyc(COND_HOLD_CYC);
		rd(CTRL_ADDR, 8'h40, 8'hFF);
		rd(STATUS_ADDR, 8'h80, 8'h80);
		wr(CTRL_ADDR, 8'h41);
		cyc(2 * COND_HOLD_CYC + 20);
		`CHK(sda_oe_o, 1'b1)
		rd(FLAG_ADDR, 8'h02, 8'hFF);
		rd(CTRL_ADDR, 8'h40, 8'hFF);
		done("start and stop");
		// another master holds the bus: no reservation, start refused
		u_bus_partner.set_data(1'b0);
		cyc(10);
		wr(FLAG_ADDR, 8'h03);
		wr(CTRL_ADDR, 8'h42);
		cyc(2);
		`CHK(sda_oe_o, 1'b1)
		rd(FLAG_ADDR, 8'hC3, 8'hFF);
		rd(CTRL_ADDR, 8'h40, 8'hFF);
		wr(CTRL_ADDR, 8'h00);
		rd(FLAG_ADDR, 8'h03, 8'hFF);
		rd(STATUS_ADDR, 8'h00, 8'hFF);
		u_bus_partner.set_data(1'b1);
		cyc(10);
		done("refused start");
		// status cleared by exit; address match and extension code wake
		wr(FLAG_ADDR, 8'h02);
		wr(CTRL_ADDR, 8'h40);
		transmit_i <= 1'b1;
		ack_det_i <= 1'b1;
		@(posedge ref_clk_i);
		transmit_i <= 1'b0;
		ack_det_i <= 1'b0;
		rd(STATUS_ADDR, 8'h0C, 8'h0C);
		for (int k = 0; k < 2; k++) begin
			wr(CTRL_ADDR, 8'h60);
			cyc(3);
			`CHK(standby_o, 1'b1)
			rd(STATUS_ADDR, 8'h00, 8'hFF);
			u_bus_partner.start_frame();
			u_bus_partner.clocks(2);
			@(posedge ref_clk_i);
			if (k == 0) begin
				addr_match_i <= 1'b1;
			end else begin
				ext_code_i <= 1'b1;
			end
			@(posedge ref_clk_i);
			addr_match_i <= 1'b0;
			ext_code_i <= 1'b0;
			cyc(3);
			`CHK(standby_o, 1'b0)
			u_bus_partner.stop_frame();
			cyc(10);
		end
		done("standby");
		// own start leaves data driven, so the cancel has a line to free
		wr(CTRL_ADDR, 8'h42);
		cyc(COND_HOLD_CYC + 5);
		`CHK({sda_o, sda_oe_o}, 2'b00)
		// ninth-clock wait while sending, then cancel
		wait_i <= 1'b1;
		ninth_wait_i <= 1'b1;
		transmit_i <= 1'b1;
		@(posedge ref_clk_i);
		transmit_i <= 1'b0;
		wr(CTRL_ADDR, 8'hC0);
		`CHK({scl_o, scl_oe_o}, 2'b00)
		n = 0;
		while (wait_release_o !== 1'b1 && n < 20) begin
			@(posedge ref_clk_i);
			n++;
		end
		`CHK(wait_release_o, 1'b1)
		if (n == 20) begin
			conclude();
		end
		wait_i <= 1'b0;
		ninth_wait_i <= 1'b0;
		cyc(2);
		`CHK(sda_oe_o, 1'b1)
		`CHK(scl_oe_o, 1'b1)
		rd(STATUS_ADDR, 8'h00, 8'h08);
		rd(CTRL_ADDR, 8'h40, 8'hFF);
		done("wait cancel");
		cyc(5);
		conclude();
	end
endmodule
`default_nettype wire
